// [pkg/nac_pkg.sv]
`default_nettype none

// ==========================================================================
// Shared constants of the nonvolatile access controller.
// ==========================================================================
package nac_pkg;

  // ========================================================================
  // Register byte offsets on the Avalon-MM slave (32-bit words).
  // ========================================================================
  localparam logic [5:0] OFS_ADDR_LOW    = 6'h00;
  localparam logic [5:0] OFS_ADDR_HIGH   = 6'h04;
  localparam logic [5:0] OFS_NVM_BYTE    = 6'h08;
  localparam logic [5:0] OFS_TABLE_LATCH = 6'h0c;
  localparam logic [5:0] OFS_CONTROL     = 6'h10;
  localparam logic [5:0] OFS_UNLOCK      = 6'h14;
  localparam logic [5:0] OFS_PERIPH_TWO  = 6'h18;

  // ========================================================================
  // Field positions of the control register and the flag register.
  // ========================================================================
  localparam int CTL_FETCH_GO   = 0;
  localparam int CTL_PROG_GO    = 1;
  localparam int CTL_PERMIT     = 2;
  localparam int CTL_ABORT      = 3;
  localparam int CTL_ERASE      = 4;
  localparam int CTL_WHOLE      = 5;
  localparam int CTL_SETUP      = 6;
  localparam int CTL_SPACE      = 7;
  localparam int FLG_STORE_DONE = 4;

  // ========================================================================
  // Reset values, unlock keys and instruction words.
  // ========================================================================
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [7:0]  UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY_B = 8'haa;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [15:0] NOP_WORD     = 16'h0000;

  // ========================================================================
  // Memory sizes.
  // ========================================================================
  localparam int EE_BYTES    = 1024;
  localparam int FLASH_BYTES = 256;
  localparam int BLOCK_BYTES = 64;
  localparam int CFG_BYTES   = 8;

  // ========================================================================
  // Timing: programming time and the clock period, both in ns.
  // ========================================================================
  localparam int PROG_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [7:0] PROG_CYCLES =
    8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Programming sequencer states.
  typedef enum logic [0:0] {PROG_IDLE, PROG_BUSY} nac_prog_state_t;

endpackage : nac_pkg

`default_nettype wire

// [verilog/nac_nvm_access_controller.sv]
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`default_nettype none


module nac_nvm_access_controller
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM register slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Table operations from the processor core.
  input  wire logic        tableFetch,
  input  wire logic        tableStore,
  input  wire logic [7:0]  tablePtr,
  // Instruction fetch port of the processor core.
  input  wire logic [6:0]  instrAddr,
  output logic      [15:0] instrWord,
  output logic             fetchStall
);

  // ========================================================================
  // Storage and registers.
  // ========================================================================
  logic [7:0]  eeMem     [nac_pkg::EE_BYTES];
  logic [7:0]  flashMem  [nac_pkg::FLASH_BYTES];
  logic [7:0]  holdBuf   [nac_pkg::BLOCK_BYTES];
  logic [7:0]  cfgMem    [nac_pkg::CFG_BYTES];

  logic [7:0]  addrLow_reg;
  logic [1:0]  addrHigh_reg;
  logic [7:0]  nvmByte_reg;
  logic [7:0]  tableLatch_reg;
  logic [7:0]  control_reg;
  logic        storeDone_reg;
  logic [1:0]  unlockStage_reg;
  logic        waitReq_reg;
  logic [31:0] readData_reg;
  logic [15:0] instrWord_reg;
  logic        fetchStall_reg;

  // Operation captured at start, so software edits cannot retarget it.
  nac_pkg::nac_prog_state_t progState_reg;
  logic [7:0]  progCount_reg;
  logic        opFlash_reg;
  logic        opSetup_reg;
  logic        opErase_reg;
  logic [9:0]  opAddr_reg;
  logic [7:0]  opData_reg;
  logic [1:0]  opBlock_reg;

  // ========================================================================
  // Bus decode.
  // ========================================================================
  logic        busReq;
  logic        wrAccept;
  logic        rdAccept;
  logic        ctlWrite;
  logic [7:0]  wrByte;
  logic        progDone;
  logic        progStart;
  logic        wholeRefused;
  logic [9:0]  eeAddr;
  logic [15:0] rawWord;

  assign busReq   = avs_read | avs_write;
  // A transfer completes at the edge where waitrequest is sampled low.
  assign wrAccept = avs_write & ~waitReq_reg & avs_byteenable[0];
  assign rdAccept = avs_read & ~waitReq_reg;
  assign wrByte   = avs_writedata[7:0];
  assign ctlWrite = wrAccept && (avs_address == nac_pkg::OFS_CONTROL);
  assign eeAddr   = {addrHigh_reg, addrLow_reg};

  // Program-go may start only with permit, an armed unlock and no request
  // for the whole array; the refused bulk case flags an improper attempt.
  assign progStart = ctlWrite && wrByte[nac_pkg::CTL_PROG_GO]
                     && !control_reg[nac_pkg::CTL_PROG_GO]
                     && wrByte[nac_pkg::CTL_PERMIT]
                     && (unlockStage_reg == 2'd2)
                     && !wrByte[nac_pkg::CTL_WHOLE];
  assign wholeRefused = ctlWrite && wrByte[nac_pkg::CTL_PROG_GO]
                        && wrByte[nac_pkg::CTL_WHOLE];
  assign progDone = (progState_reg == nac_pkg::PROG_BUSY)
                    && (progCount_reg == 8'd1);

  // ========================================================================
  // Avalon handshake: one wait cycle, then the transfer.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      waitReq_reg <= 1'b1;
    else
      waitReq_reg <= ~(busReq & waitReq_reg);
  end

  // Read data is prepared in the wait cycle so it stands with the answer.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      readData_reg <= 32'h0000_0000;
    else if (avs_read && waitReq_reg)
    begin
      unique case (avs_address)
        nac_pkg::OFS_ADDR_LOW:    readData_reg <= {24'h00_0000, addrLow_reg};
        nac_pkg::OFS_ADDR_HIGH:   readData_reg <= {30'h0000_0000, addrHigh_reg};
        nac_pkg::OFS_NVM_BYTE:    readData_reg <= {24'h00_0000, nvmByte_reg};
        nac_pkg::OFS_TABLE_LATCH: readData_reg <= {24'h00_0000, tableLatch_reg};
        nac_pkg::OFS_CONTROL:     readData_reg <= {24'h00_0000, control_reg};
        nac_pkg::OFS_PERIPH_TWO:
          readData_reg <= {27'h000_0000, storeDone_reg, 4'h0};
        // Unlock port and unmapped words read zero.
        default:                  readData_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Plain address registers.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrLow_reg  <= nac_pkg::RST_BYTE;
      addrHigh_reg <= 2'b00;
    end
    else if (wrAccept)
    begin
      if (avs_address == nac_pkg::OFS_ADDR_LOW)
        addrLow_reg <= wrByte;
      if (avs_address == nac_pkg::OFS_ADDR_HIGH)
        addrHigh_reg <= wrByte[1:0];
    end
  end

  // ========================================================================
  // Unlock sequencer: key A then key B arms one program-go.
  // ========================================================================
  // The port keeps only the sequence position, never the written byte.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      unlockStage_reg <= 2'd0;
    else if (wrAccept && (avs_address == nac_pkg::OFS_UNLOCK))
    begin
      if (wrByte == nac_pkg::UNLOCK_KEY_A)
        unlockStage_reg <= 2'd1;
      else if (wrByte == nac_pkg::UNLOCK_KEY_B && unlockStage_reg == 2'd1)
        unlockStage_reg <= 2'd2;
      else
        unlockStage_reg <= 2'd0;
    end
    else if (wrAccept)
      unlockStage_reg <= 2'd0;
  end

  // ========================================================================
  // Control register, shared by both memories.
  // ========================================================================
  // Hardware events are applied after the software write so they win.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      control_reg <= 8'h00;
    else
    begin
      if (ctlWrite)
      begin
        control_reg[nac_pkg::CTL_PERMIT] <= wrByte[nac_pkg::CTL_PERMIT];
        control_reg[nac_pkg::CTL_ABORT]  <= wrByte[nac_pkg::CTL_ABORT];
        control_reg[nac_pkg::CTL_ERASE]  <= wrByte[nac_pkg::CTL_ERASE];
        control_reg[nac_pkg::CTL_WHOLE]  <= 1'b0;
        control_reg[nac_pkg::CTL_SETUP]  <= wrByte[nac_pkg::CTL_SETUP];
        control_reg[nac_pkg::CTL_SPACE]  <= wrByte[nac_pkg::CTL_SPACE];
        if (wrByte[nac_pkg::CTL_FETCH_GO] && !wrByte[nac_pkg::CTL_SPACE]
            && !control_reg[nac_pkg::CTL_PROG_GO])
          control_reg[nac_pkg::CTL_FETCH_GO] <= 1'b1;
      end
      // Fetch completes in one cycle, then the bit drops.
      if (control_reg[nac_pkg::CTL_FETCH_GO])
        control_reg[nac_pkg::CTL_FETCH_GO] <= 1'b0;
      if (progStart)
      begin
        control_reg[nac_pkg::CTL_PROG_GO] <= 1'b1;
        control_reg[nac_pkg::CTL_ABORT]   <= 1'b1;
      end
      if (wholeRefused)
        control_reg[nac_pkg::CTL_ABORT] <= 1'b1;
      if (progDone)
      begin
        control_reg[nac_pkg::CTL_PROG_GO] <= 1'b0;
        control_reg[nac_pkg::CTL_ABORT]   <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Store-done flag in the second peripheral flag register.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      storeDone_reg <= 1'b0;
    else if (progDone)
      storeDone_reg <= 1'b1;
    else if (wrAccept && (avs_address == nac_pkg::OFS_PERIPH_TWO))
      storeDone_reg <= wrByte[nac_pkg::FLG_STORE_DONE];
  end

  // ========================================================================
  // Programming sequencer with its internal timer.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      progState_reg <= nac_pkg::PROG_IDLE;
      progCount_reg <= 8'd0;
      opFlash_reg   <= 1'b0;
      opSetup_reg   <= 1'b0;
      opErase_reg   <= 1'b0;
      opAddr_reg    <= 10'd0;
      opData_reg    <= nac_pkg::RST_BYTE;
      opBlock_reg   <= 2'd0;
    end
    else
    begin
      unique case (progState_reg)
        nac_pkg::PROG_IDLE:
        begin
          if (progStart)
          begin
            progState_reg <= nac_pkg::PROG_BUSY;
            progCount_reg <= nac_pkg::PROG_CYCLES;
            opSetup_reg   <= wrByte[nac_pkg::CTL_SETUP];
            opFlash_reg   <= wrByte[nac_pkg::CTL_SPACE];
            opErase_reg   <= wrByte[nac_pkg::CTL_ERASE];
            opAddr_reg    <= eeAddr;
            opData_reg    <= nvmByte_reg;
            opBlock_reg   <= tablePtr[7:6];
          end
        end
        nac_pkg::PROG_BUSY:
        begin
          progCount_reg <= progCount_reg - 8'd1;
          if (progDone)
            progState_reg <= nac_pkg::PROG_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Nonvolatile arrays, written only when the timer ends.
  // ========================================================================
  // Contents carry no reset: they model retained storage.
  always_ff @(posedge mclk)
  begin
    if (progDone && opSetup_reg)
      cfgMem[opAddr_reg[2:0]] <= opData_reg;
    else if (progDone && !opFlash_reg)
      eeMem[opAddr_reg] <= opData_reg;
  end

  // A whole 64-byte block commits at once, erased or from the buffer.
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < nac_pkg::BLOCK_BYTES; i++)
    begin
      if (progDone && opFlash_reg && !opSetup_reg)
        flashMem[{opBlock_reg, 6'(i)}] <=
          opErase_reg ? nac_pkg::ERASED_BYTE : holdBuf[i];
    end
  end

  // ========================================================================
  // Holding buffer filled by table stores.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < nac_pkg::BLOCK_BYTES; i++)
        holdBuf[i] <= nac_pkg::ERASED_BYTE;
    end
    else if (progDone && opFlash_reg && !opSetup_reg)
    begin
      for (int i = 0; i < nac_pkg::BLOCK_BYTES; i++)
        holdBuf[i] <= nac_pkg::ERASED_BYTE;
    end
    else if (tableStore && !fetchStall_reg)
      holdBuf[tablePtr[5:0]] <= tableLatch_reg;
  end

  // ========================================================================
  // Table latch: the single byte-wide path between the two spaces.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tableLatch_reg <= nac_pkg::RST_BYTE;
    else if (tableFetch && !fetchStall_reg)
    begin
      if (control_reg[nac_pkg::CTL_SETUP])
        tableLatch_reg <= cfgMem[tablePtr[2:0]];
      else
        tableLatch_reg <= flashMem[tablePtr];
    end
    else if (wrAccept && (avs_address == nac_pkg::OFS_TABLE_LATCH))
      tableLatch_reg <= wrByte;
  end

  // ========================================================================
  // Data byte register: written by software, loaded by a fetch.
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      nvmByte_reg <= nac_pkg::RST_BYTE;
    else if (control_reg[nac_pkg::CTL_FETCH_GO])
    begin
      if (control_reg[nac_pkg::CTL_SETUP])
        nvmByte_reg <= cfgMem[addrLow_reg[2:0]];
      else
        nvmByte_reg <= eeMem[eeAddr];
    end
    else if (wrAccept && (avs_address == nac_pkg::OFS_NVM_BYTE))
      nvmByte_reg <= wrByte;
  end

  // ========================================================================
  // Instruction fetch port.
  // ========================================================================
  // Program space is 16 bits wide: two flash bytes, low byte first.
  assign rawWord = {flashMem[{instrAddr, 1'b1}], flashMem[{instrAddr, 1'b0}]};

  // The erased pattern decodes to nothing, so it issues as a no-op. While
  // a flash operation runs the word is held at no-op as well.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      instrWord_reg <= nac_pkg::NOP_WORD;
    else if (fetchStall_reg || rawWord == nac_pkg::ERASED_WORD)
      instrWord_reg <= nac_pkg::NOP_WORD;
    else
      instrWord_reg <= rawWord;
  end

  // Stall rises the cycle after a flash start and drops with completion.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fetchStall_reg <= 1'b0;
    else if (progDone)
      fetchStall_reg <= 1'b0;
    else if (progStart && wrByte[nac_pkg::CTL_SPACE]
             && !wrByte[nac_pkg::CTL_SETUP])
      fetchStall_reg <= 1'b1;
  end

  // ========================================================================
  // Outputs, all from flip-flops.
  // ========================================================================
  assign avs_readdata    = readData_reg;
  assign avs_waitrequest = waitReq_reg;
  assign instrWord       = instrWord_reg;
  assign fetchStall      = fetchStall_reg;

endmodule // nac_nvm_access_controller

`default_nettype wire

// [dv/nac_nvm_access_controller_assertions.sv]
`default_nettype none
// ====================
// Port checker of the access controller.
// ====================
module nac_nvm_access_controller_assertions
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Core side.
  input wire logic [15:0] instrWord,
  input wire logic        fetchStall
);
  logic [7:0] stallCnt;
  logic       ctlWr;

  // A finished write to the control register.
  assign ctlWr = avs_write && !avs_waitrequest && avs_address == nac_pkg::OFS_CONTROL;

  // Stall length so far; a runaway timer shows up as a long stall.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      stallCnt <= 8'h00;
    else
      stallCnt <= fetchStall ? stallCnt + 8'h01 : 8'h00;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("Request not answered after one wait cycle.");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle.");
  ack_req_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("Answer without a request.");
  unlock_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == nac_pkg::OFS_UNLOCK |-> avs_readdata == 32'h0)
    else $error("Unlock port read not zero.");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("Read data wider than one byte.");
  data_hold_a: assert property ($changed(avs_readdata) |->
    avs_read && !avs_waitrequest) else $error("Read data moved outside an answer.");
  stall_start_a: assert property ($rose(fetchStall) |-> $past(ctlWr) ||
    $past(ctlWr, 2)) else $error("Stall began without a control write.");
  stall_len_a: assert property ($fell(fetchStall) |->
    stallCnt >= nac_pkg::PROG_CYCLES - 8'h02 && stallCnt <= nac_pkg::PROG_CYCLES)
    else $error("Stall length differs from the programming timer.");
  stall_nop_a: assert property (fetchStall && $past(fetchStall) |->
    instrWord == nac_pkg::NOP_WORD) else $error("Instruction issued during a stall.");
endmodule // nac_nvm_access_controller_assertions

bind nac_nvm_access_controller nac_nvm_access_controller_assertions i_chk (.mclk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .instrWord,
  .fetchStall);
`default_nettype wire

// [dv/nac_core_model.sv]
`default_nettype none
// ====================
// Processor core model: table pulses and instruction fetch.
// ====================
module nac_core_model
(
  // Clock.
  input  wire logic        mclk,
  // Toward the controller.
  output var  logic        tableFetch,
  output var  logic        tableStore,
  output var  logic [7:0]  tablePtr,
  output var  logic [6:0]  instrAddr,
  // From the controller.
  input  wire logic [15:0] instrWord
);
  // Quiet strobes from time zero, so no unknown pulse reaches the latch.
  initial
  begin
    tableFetch = 1'b0;
    tableStore = 1'b0;
    tablePtr   = 8'h00;
    instrAddr  = 7'h00;
  end

  // One-cycle table pulse at any byte address; the pointer stays for the block pick.
  task automatic tbl(input logic st, input logic [7:0] ptr);
    @(posedge mclk);
    tablePtr   <= ptr;
    tableStore <= st;
    tableFetch <= !st;
    @(posedge mclk);
    tableStore <= 1'b0;
    tableFetch <= 1'b0;
  endtask

  // The word is registered one cycle after the address.
  task automatic fetch(input logic [6:0] a, output logic [15:0] w);
    @(posedge mclk);
    instrAddr <= a;
    repeat (2) @(posedge mclk);
    w = instrWord;
  endtask
endmodule // nac_core_model
`default_nettype wire

// [dv/nac_nvm_access_controller_bench.sv]
`default_nettype none
// ====================
// Self-checking bench of the access controller.
// ====================
module nac_nvm_access_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        tableFetch, tableStore, fetchStall;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, d;
  logic [7:0]  tablePtr, ed, blk [64];
  logic [6:0]  instrAddr;
  logic [15:0] instrWord, iw, ew;
  logic [9:0]  ea [2];
  logic [7:0]  ev [2];
  logic [1:0]  b;
  int          fail_count = 0;
  int          num_checks = 0;
  int          i, j;

  nac_nvm_access_controller i_nac_nvm_access_controller (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tableFetch, .tableStore, .tablePtr, .instrAddr, .instrWord, .fetchStall);
  nac_core_model i_nac_core_model (.mclk, .tableFetch, .tableStore, .tablePtr, .instrAddr,
    .instrWord);

  // Free-running 40 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A hung handshake must still end the run.
  initial
  begin
    #500000;
    fail_count++;
    give_verdict();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low.
  // A slave that never answers is left to the watchdog, which ends the run.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dv);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= dv;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Unlock keys, then the control write that starts programming.
  task automatic start(input logic [31:0] ctl);
    bus(1'b1, nac_pkg::OFS_UNLOCK, 32'(nac_pkg::UNLOCK_KEY_A));
    bus(1'b1, nac_pkg::OFS_UNLOCK, 32'(nac_pkg::UNLOCK_KEY_B));
    bus(1'b1, nac_pkg::OFS_CONTROL, ctl);
  endtask

  // Busy checks, a clear attempt on program-go that sets abort again, so
  // only the timer can clear abort, then a bounded poll.
  task automatic wait_done(input logic fl, input logic [31:0] ctl);
    int n;
    rdc(nac_pkg::OFS_CONTROL, ctl | 32'h08);
    chk(32'(fetchStall), 32'(fl));
    bus(1'b1, nac_pkg::OFS_CONTROL, (ctl & 32'hfd) | 32'h08);
    bus(1'b0, nac_pkg::OFS_CONTROL, 32'h0);
    chk(32'(rd[1]), 32'h1);
    for (n = 0; n < 60 && rd[1] !== 1'b0; n++)
      bus(1'b0, nac_pkg::OFS_CONTROL, 32'h0);
    chk(32'(rd[3:1]), 32'h2);
    rdc(nac_pkg::OFS_PERIPH_TWO, 32'h10);
    bus(1'b1, nac_pkg::OFS_PERIPH_TWO, 32'h0);
    rdc(nac_pkg::OFS_PERIPH_TWO, 32'h0);
  endtask

  // Expected instruction word; an erased word runs as a no-op.
  function automatic logic [15:0] instr_exp(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo} == nac_pkg::ERASED_WORD ? nac_pkg::NOP_WORD : {hi, lo};
  endfunction

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    void'($urandom(32'he9ec));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++)
      rdc(6'(i * 4), 32'h0);
    for (i = 0; i < 6; i++)
    begin
      d = 32'($urandom);
      if (i == 0)
        ed = d[7:0];
      bus(1'b1, 6'(i * 4), d);
      rdc(6'(i * 4), i == 4 ? (d & 32'hdc) | (32'(d[1] & d[5]) << 3) : i == 5 ? 32'h0 :
          i == 1 ? d & 32'h3 : d & 32'hff);
      bus(1'b1, nac_pkg::OFS_CONTROL, 32'h0);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, nac_pkg::OFS_ADDR_LOW, 32'(~ed));
    avs_byteenable <= 4'hf;
    rdc(nac_pkg::OFS_ADDR_LOW, 32'(ed));
    bus(1'b1, nac_pkg::OFS_CONTROL, 32'h06);
    rdc(nac_pkg::OFS_CONTROL, 32'h04);
    start(32'h02);
    rdc(nac_pkg::OFS_CONTROL, 32'h00);
    // Two EEPROM bytes that differ in the top address bit.
    for (i = 0; i < 2; i++)
    begin
      ea[i] = 10'($urandom);
      ea[i][9] = i[0];
      ev[i] = 8'($urandom);
      bus(1'b1, nac_pkg::OFS_ADDR_LOW, 32'(ea[i][7:0]));
      bus(1'b1, nac_pkg::OFS_ADDR_HIGH, 32'(ea[i][9:8]));
      bus(1'b1, nac_pkg::OFS_NVM_BYTE, 32'(ev[i]));
      start(32'h06);
      wait_done(1'b0, 32'h06);
    end
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, nac_pkg::OFS_ADDR_LOW, 32'(ea[i][7:0]));
      bus(1'b1, nac_pkg::OFS_ADDR_HIGH, 32'(ea[i][9:8]));
      bus(1'b1, nac_pkg::OFS_NVM_BYTE, 32'(~ev[i]));
      bus(1'b1, nac_pkg::OFS_CONTROL, 32'h01);
      rdc(nac_pkg::OFS_NVM_BYTE, 32'(ev[i]));
      rdc(nac_pkg::OFS_CONTROL, 32'h00);
    end
    bus(1'b1, nac_pkg::OFS_NVM_BYTE, 32'h5a);
    bus(1'b1, nac_pkg::OFS_CONTROL, 32'h81);
    rdc(nac_pkg::OFS_NVM_BYTE, 32'h5a);
    // Fill one flash block through the latch, then commit and erase it.
    b = 2'($urandom);
    for (j = 0; j < 64; j++)
    begin
      blk[j] = j < 2 ? nac_pkg::ERASED_BYTE : 8'($urandom);
      bus(1'b1, nac_pkg::OFS_TABLE_LATCH, 32'(blk[j]));
      i_nac_core_model.tbl(1'b1, {b, 6'(j)});
    end
    for (i = 0; i < 2; i++)
    begin
      start(i == 0 ? 32'h86 : 32'h96);
      wait_done(1'b1, i == 0 ? 32'h86 : 32'h96);
      for (j = 0; j < 4; j++)
      begin
        d = 32'($urandom_range(63));
        i_nac_core_model.tbl(1'b0, {b, d[5:0]});
        rdc(nac_pkg::OFS_TABLE_LATCH, i == 0 ? 32'(blk[d[5:0]]) : 32'hff);
        d = j == 0 ? 32'h0 : 32'($urandom_range(31));
        ew = i == 0 ? instr_exp(blk[2 * d[4:0]], blk[2 * d[4:0] + 1]) : nac_pkg::NOP_WORD;
        i_nac_core_model.fetch({b, d[4:0]}, iw);
        chk(32'(iw), 32'(ew));
      end
    end
    start(32'ha6);
    bus(1'b0, nac_pkg::OFS_CONTROL, 32'h0);
    chk(rd & 32'h0f, 32'h0c);
    chk(32'(fetchStall), 32'h0);
    ed = 8'($urandom);
    bus(1'b1, nac_pkg::OFS_ADDR_LOW, 32'h3);
    bus(1'b1, nac_pkg::OFS_NVM_BYTE, 32'(ed));
    start(32'h46);
    wait_done(1'b0, 32'h46);
    bus(1'b1, nac_pkg::OFS_NVM_BYTE, 32'(~ed));
    bus(1'b1, nac_pkg::OFS_CONTROL, 32'h41);
    rdc(nac_pkg::OFS_NVM_BYTE, 32'(ed));
    i_nac_core_model.tbl(1'b0, 8'h03);
    rdc(nac_pkg::OFS_TABLE_LATCH, 32'(ed));
    give_verdict();
  end
endmodule // nac_nvm_access_controller_bench
`default_nettype wire
